// *** core/async_serial_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_defs.svh"
module async_serial_unit
  import async_serial_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        serialInPin,
  input  wire logic        baudClockIn,
  output logic             serialOutPin,
  output logic             rxCompleteIrq,
  output logic             txBufferFreeIrq
);
  typedef struct packed {
    logic [7:0]  ctl0;
    logic [7:0]  clkSel;
    logic [7:0]  baudDiv;
    logic [7:0]  opt;
    logic [2:0]  errFlags;
    logic [7:0]  rxBuf;
    logic        rxFull;
    logic [7:0]  txBuf;
    logic        txPending;
    logic        aValid;
    logic        aWrite;
    logic [7:0]  aAddr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        rxIrq;
    logic        txIrq;
    logic        txOut;
    txState_t    txState;
    logic [11:0] txShift;
    logic [3:0]  txBits;
    logic [7:0]  txCnt;
    rxState_t    rxState;
    logic [7:0]  rxShift;
    logic [3:0]  rxBits;
    logic [7:0]  rxCnt;
    logic        rxPar;
  } unitState_t;

  unitState_t q;
  unitState_t d;

  logic        tick;
  logic [1:0]  enSync;
  logic        power;
  logic        txEn;
  logic        rxEn;
  logic        rxIn;
  logic        txInv;
  logic        lsbFirst;
  logic        len8;
  logic [1:0]  parMode;
  logic [3:0]  len;
  logic [7:0]  div;
  logic [7:0]  half;
  logic        take;
  logic        txSample;
  logic        rxSample;
  logic [11:0] frame;
  logic [7:0]  txData;
  logic [7:0]  rxData;
  logic        parErr;
  logic        frmErr;
  logic [11:0] txNext;
  // Transfer size is not decoded: each register is one byte in the low lane of its word.

  assign power    = q.ctl0[`BIT_POWER];
  assign txInv    = q.opt[`BIT_TX_INVERT];
  assign lsbFirst = q.ctl0[`BIT_ORDER];
  assign len8     = q.ctl0[`BIT_CHAR_LEN];
  assign parMode  = q.ctl0[`BIT_PARITY_HI:`BIT_PARITY_LO];
  assign len      = len8 ? 4'h8 : 4'h7;
  assign txEn     = power & enSync[1];
  assign rxEn     = power & enSync[0];
  assign rxIn     = serialInPin ^ q.opt[`BIT_RX_INVERT];
  assign div      = (q.baudDiv < `MIN_DIVISOR) ? `MIN_DIVISOR : q.baudDiv;
  assign half     = div >> 1;
  assign take     = hsel & hready & htrans[1];
  assign txSample = tick & (q.txCnt == div - 8'h01);
  assign rxSample = tick & (q.rxCnt == div - 8'h01);

  // Enables pass two flip-flops, so they act two clocks after they rise.
  serial_enable_sync #(
    .WIDTH(2)
  ) serial_enable_sync_i (
    .mclk  (mclk),
    .rst   (rst),
    .clkEn (clkEn),
    .din   ({q.ctl0[`BIT_TX_ENABLE] & power, q.ctl0[`BIT_RX_ENABLE] & power}),
    .dout  (enSync)
  );

  serial_baud_gen #(
    .PRESCALE_W(11)
  ) serial_baud_gen_i (
    .mclk        (mclk),
    .rst         (rst),
    .clkEn       (clkEn),
    .run         (power),
    .sel         (q.clkSel[3:0]),
    .baudClockIn (baudClockIn),
    .tick        (tick)
  );

  // Transmit frame, least significant position leaves the pin first.
  always_comb begin
    txData = len8 ? q.txBuf : {1'b0, q.txBuf[6:0]};
    frame    = 12'hfff;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(len)) begin
        frame[i+1] = lsbFirst ? q.txBuf[i] : q.txBuf[int'(len) - 1 - i];
      end
    end
    if (parMode != 2'b00) begin
      frame[len+4'h1] = parityBit(parMode, txData);
    end
  end

  // Received character; seven-bit LSB-first data sits high in the shifter.
  always_comb begin
    if (!len8 && lsbFirst) begin
      rxData = {1'b0, q.rxShift[7:1]};
    end else if (!len8) begin
      rxData = {1'b0, q.rxShift[6:0]};
    end else begin
      rxData = q.rxShift;
    end
    parErr = (parMode != 2'b00) && (q.rxPar != parityBit(parMode, rxData));
    frmErr = !rxIn;
  end

  assign txNext = {1'b1, q.txShift[11:1]};

  always_comb begin
    d           = q;
    d.rxIrq     = 1'b0;
    d.txIrq     = 1'b0;
    d.hreadyout = 1'b1;
    d.hresp     = 1'b0;

    // Address phase: read data is fetched here so the data phase has no wait state.
    d.aValid = take;
    d.aWrite = hwrite;
    d.aAddr  = haddr[7:0];
    if (take && !hwrite) begin
      if (haddr[7:0] == `OFF_SERIAL_CONTROL_0) begin
        d.hrdata = {24'h0, q.ctl0};
      end else if (haddr[7:0] == `OFF_SERIAL_CLOCK_SELECT) begin
        d.hrdata = {24'h0, q.clkSel};
      end else if (haddr[7:0] == `OFF_SERIAL_BAUD_DIVISOR) begin
        d.hrdata = {24'h0, q.baudDiv};
      end else if (haddr[7:0] == `OFF_SERIAL_OPTION_CONTROL) begin
        d.hrdata = {24'h0, q.opt};
      end else if (haddr[7:0] == `OFF_RECEPTION_ERROR_FLAGS) begin
        d.hrdata   = {29'h0, q.errFlags};
        d.errFlags = 3'h0;
      end else if (haddr[7:0] == `OFF_RECEIVE_BUFFER) begin
        d.hrdata = {24'h0, q.rxBuf};
        d.rxFull = 1'b0;
      end else if (haddr[7:0] == `OFF_TRANSMIT_BUFFER) begin
        d.hrdata = {24'h0, q.txBuf};
      end else begin
        d.hrdata = 32'h0;
      end
    end

    // Transmitter.
    case (q.txState)
      TX_IDLE: begin
        d.txOut = 1'b1 ^ txInv;
        if (txEn && q.txPending) begin
          d.txShift   = frame;
          d.txBits    = 4'h2 + len + {3'h0, parMode != 2'b00} + {3'h0, q.ctl0[`BIT_STOP_LEN]};
          d.txCnt     = 8'h00;
          d.txPending = 1'b0;
          d.txIrq     = 1'b1;
          d.txOut     = frame[0] ^ txInv;
          d.txState   = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (txSample) begin
          d.txCnt   = 8'h00;
          d.txShift = txNext;
          d.txBits  = q.txBits - 4'h1;
          if (q.txBits == 4'h1) begin
            d.txOut   = 1'b1 ^ txInv;
            d.txState = TX_IDLE;
          end else begin
            d.txOut = txNext[0] ^ txInv;
          end
        end else if (tick) begin
          d.txCnt = q.txCnt + 8'h01;
        end
      end
      default: d.txState = TX_IDLE;
    endcase
    if (!txEn) begin
      d.txState = TX_IDLE;
      d.txOut   = 1'b1 ^ txInv;
    end

    // Receiver; a low line in idle starts a frame even right after enabling.
    case (q.rxState)
      RX_IDLE: begin
        if (!rxIn) begin
          d.rxState = RX_START;
          d.rxCnt   = 8'h00;
        end
      end
      RX_START: begin
        if (tick && q.rxCnt == half - 8'h01) begin
          d.rxCnt   = 8'h00;
          d.rxBits  = 4'h0;
          d.rxShift = 8'h00;
          d.rxState = rxIn ? RX_IDLE : RX_DATA;
        end else if (tick) begin
          d.rxCnt = q.rxCnt + 8'h01;
        end
      end
      RX_DATA: begin
        if (rxSample) begin
          d.rxCnt   = 8'h00;
          d.rxShift = lsbFirst ? {rxIn, q.rxShift[7:1]} : {q.rxShift[6:0], rxIn};
          d.rxBits  = q.rxBits + 4'h1;
          if (q.rxBits == len - 4'h1) begin
            d.rxState = (parMode != 2'b00) ? RX_PARITY : RX_STOP;
          end
        end else if (tick) begin
          d.rxCnt = q.rxCnt + 8'h01;
        end
      end
      RX_PARITY: begin
        if (rxSample) begin
          d.rxCnt   = 8'h00;
          d.rxPar   = rxIn;
          d.rxState = RX_STOP;
        end else if (tick) begin
          d.rxCnt = q.rxCnt + 8'h01;
        end
      end
      RX_STOP: begin
        // A frame finishing as the receiver turns off is dropped whole.
        if (rxSample && rxEn) begin
          // Flags are set after the read clear above, so a new error is never lost.
          d.errFlags[`BIT_ERR_PARITY]  = d.errFlags[`BIT_ERR_PARITY] | parErr;
          d.errFlags[`BIT_ERR_FRAMING] = d.errFlags[`BIT_ERR_FRAMING] | frmErr;
          d.errFlags[`BIT_ERR_OVERRUN] = d.errFlags[`BIT_ERR_OVERRUN] | q.rxFull;
          d.rxBuf   = rxData;
          d.rxFull  = 1'b1;
          d.rxIrq   = 1'b1;
          d.rxCnt   = 8'h00;
          d.rxState = RX_IDLE;
        end else if (tick) begin
          d.rxCnt = q.rxCnt + 8'h01;
        end
      end
      default: d.rxState = RX_IDLE;
    endcase
    if (!rxEn) begin
      d.rxState = RX_IDLE;
    end

    // Data phase write; lands after the machines so a new character is never dropped.
    if (q.aValid && q.aWrite) begin
      if (q.aAddr == `OFF_SERIAL_CONTROL_0) begin
        d.ctl0 = hwdata[7:0];
        if (power && (q.ctl0[`BIT_TX_ENABLE] || q.ctl0[`BIT_RX_ENABLE])) begin
          d.ctl0[`BIT_ORDER] = q.ctl0[`BIT_ORDER];
        end
      end else if (q.aAddr == `OFF_SERIAL_CLOCK_SELECT) begin
        d.clkSel = hwdata[7:0];
      end else if (q.aAddr == `OFF_SERIAL_BAUD_DIVISOR) begin
        d.baudDiv = hwdata[7:0];
      end else if (q.aAddr == `OFF_SERIAL_OPTION_CONTROL) begin
        d.opt = hwdata[7:0];
      end else if (q.aAddr == `OFF_TRANSMIT_BUFFER) begin
        d.txBuf     = hwdata[7:0];
        d.txPending = 1'b1;
      end
    end

    // Power off holds the serial side in reset; the line rests at its idle level.
    if (!power) begin
      d.txState   = TX_IDLE;
      d.rxState   = RX_IDLE;
      d.txPending = 1'b0;
      d.rxFull    = 1'b0;
      d.errFlags  = 3'h0;
      d.txOut     = 1'b1 ^ txInv;
      d.txIrq     = 1'b0;
      d.rxIrq     = 1'b0;
      // Counters restart too, so a frame cut by power-off never resumes half way.
      d.txCnt     = 8'h00;
      d.txBits    = 4'h0;
      d.txShift   = 12'hfff;
      d.rxCnt     = 8'h00;
      d.rxBits    = 4'h0;
      d.rxShift   = 8'h00;
      d.rxPar     = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q           <= '0;
      q.ctl0      <= `RST_SERIAL_CONTROL_0;
      q.clkSel    <= `RST_SERIAL_CLOCK_SELECT;
      q.baudDiv   <= `RST_SERIAL_BAUD_DIVISOR;
      q.opt       <= `RST_SERIAL_OPTION_CONTROL;
      q.hreadyout <= 1'b1;
      q.txOut     <= 1'b1;
      q.txState   <= TX_IDLE;
      q.rxState   <= RX_IDLE;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign hreadyout       = q.hreadyout;
  assign hrdata          = q.hrdata;
  assign hresp           = q.hresp;
  assign serialOutPin    = q.txOut;
  assign rxCompleteIrq   = q.rxIrq;
  assign txBufferFreeIrq = q.txIrq;
endmodule : async_serial_unit
`default_nettype wire

// *** core/async_serial_defs.svh ***
// Notes on behaviour
// - While receiving, any parity, framing or overrun error raises the receive interrupt.
// - Moving a received frame into the receive buffer pulses the receive interrupt.
// - Loading the transmit shifter from the buffer pulses the transmit interrupt.
// - Seven or eight data bits both ways; one or two stop bits on transmit.
// - Receiver detects parity, framing and overrun; parity odd, even, zero or none.
// - Bit rate spans 300 bps to 312.5 kbps.
// - Bit timing comes from the own generator, internal prescaler or baud clock pin.
// - Errors set their flag; reading the flag register clears all flags.
// - Receive shifter collects serial bits and hands the character over after the stop bit.
// - Seven-bit LSB-first reception stores zero in the top buffer bit.
// - Writing the transmit buffer starts a transmission.
// - The loaded transmit shifter drives its bits out on the serial output pin.
// - Control register 0 takes byte or bit writes and resets to 10H.
// - Enabling the receiver while the line is low starts a reception at once.
// - Neither shift register is visible to software.
// - Power bit low stops and resets the serial unit; output sits at idle level.
// - Transmit and receive enables take effect two clocks after rising.
// - With receive disabled, no receive interrupt and no receive buffer update.
// - Bit order changes only while power is off or both enables are off.
`ifndef ASYNC_SERIAL_DEFS_SVH
`define ASYNC_SERIAL_DEFS_SVH
`define OFF_SERIAL_CONTROL_0      8'h00
`define OFF_SERIAL_CLOCK_SELECT   8'h04
`define OFF_SERIAL_BAUD_DIVISOR   8'h08
`define OFF_SERIAL_OPTION_CONTROL 8'h0c
`define OFF_RECEPTION_ERROR_FLAGS 8'h10
`define OFF_RECEIVE_BUFFER        8'h14
`define OFF_TRANSMIT_BUFFER       8'h18
`define RST_SERIAL_CONTROL_0      8'h10
`define RST_SERIAL_CLOCK_SELECT   8'h00
`define RST_SERIAL_BAUD_DIVISOR   8'h20
`define RST_SERIAL_OPTION_CONTROL 8'h00
`define BIT_POWER                 7
`define BIT_TX_ENABLE             6
`define BIT_RX_ENABLE             5
`define BIT_ORDER                 4
`define BIT_PARITY_HI             3
`define BIT_PARITY_LO             2
`define BIT_CHAR_LEN              1
`define BIT_STOP_LEN              0
`define BIT_TX_INVERT             1
`define BIT_RX_INVERT             0
`define BIT_ERR_PARITY            2
`define BIT_ERR_FRAMING           1
`define BIT_ERR_OVERRUN           0
`define MIN_DIVISOR               8'h04
`define CLKSEL_EXTERNAL           4'hc
`endif

// *** core/async_serial_pkg.sv ***
package async_serial_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} txState_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rxState_t;

  // Parity mode 00 none, 01 forced zero, 10 odd, 11 even.
  function automatic logic parityBit(input logic [1:0] mode, input logic [7:0] data);
    logic p;
    p = ^data;
    if (mode == 2'b10) begin
      parityBit = ~p;
    end else if (mode == 2'b11) begin
      parityBit = p;
    end else begin
      parityBit = 1'b0;
    end
  endfunction : parityBit
endpackage : async_serial_pkg

// *** core/serial_enable_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_enable_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } syncState_t;

  syncState_t q;
  syncState_t d;

  always_comb begin
    d        = q;
    d.stage1 = din;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign dout = q.stage2;
endmodule : serial_enable_sync
`default_nettype wire

// *** core/serial_baud_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_defs.svh"
module serial_baud_gen #(
  parameter int PRESCALE_W = 11
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  input  wire logic       run,
  input  wire logic [3:0] sel,
  input  wire logic       baudClockIn,
  output logic            tick
);
  typedef struct packed {
    logic [PRESCALE_W-1:0] cnt;
    logic                  extPrev;
    logic                  tick;
  } baudState_t;

  baudState_t q;
  baudState_t d;
  logic [PRESCALE_W-1:0] mask;

  // Settings 0 to 11 divide the clock by a power of two; 12 and above use the pin.
  always_comb begin
    d         = q;
    mask      = ~({PRESCALE_W{1'b1}} << sel);
    d.extPrev = baudClockIn;
    d.cnt     = q.cnt + 1'b1;
    if (!run) begin
      d.cnt  = '0;
      d.tick = 1'b0;
    end else if (sel >= `CLKSEL_EXTERNAL) begin
      d.tick = baudClockIn & ~q.extPrev;
    end else begin
      d.tick = (q.cnt & mask) == mask;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule : serial_baud_gen
`default_nettype wire

// *** bench/async_serial_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_defs.svh"
module async_serial_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        serialInPin,
  input wire logic        baudClockIn,
  input wire logic        serialOutPin,
  input wire logic        rxCompleteIrq,
  input wire logic        txBufferFreeIrq
);
  logic       wr_q;
  logic [7:0] ctl_q;
  // Control register 0 is rebuilt from bus writes; output inversion is assumed off.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q  <= 1'b0;
      ctl_q <= `RST_SERIAL_CONTROL_0;
    end else if (clkEn) begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == `OFF_SERIAL_CONTROL_0;
      if (wr_q) begin
        ctl_q <= hwdata[7:0];
      end
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence txLoad;
    txBufferFreeIrq;
  endsequence
  sequence startBit;
    !serialOutPin [*3];
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stall or error");
  high_bits_a: assert property (hrdata[31:8] == 24'h0) else $error("read data above byte");
  load_enabled_a: assert property (txLoad |-> ctl_q[7] && ctl_q[6]) else $error("load while off");
  start_bit_a: assert property (txLoad |-> startBit) else $error("no start bit at load");
  load_spacing_a: assert property (txLoad |=> !txBufferFreeIrq [*8]) else $error("load too soon");
  rx_pulse_a: assert property (rxCompleteIrq |=> !rxCompleteIrq [*8]) else $error("receive pulse");
  power_idle_a: assert property (!ctl_q[7] && !$past(ctl_q[7]) |->
    serialOutPin && !txBufferFreeIrq && !rxCompleteIrq) else $error("unit active while off");
  rx_quiet_a: assert property ((!ctl_q[5]) [*4] |-> !rxCompleteIrq) else $error("receive while off");
endmodule : async_serial_checker

bind async_serial_unit async_serial_checker async_serial_checker_i (
  .mclk, .rst, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
  .hrdata, .hresp, .serialInPin, .baudClockIn, .serialOutPin, .rxCompleteIrq, .txBufferFreeIrq
);
`default_nettype wire

// *** bench/serial_line_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_line_partner (
  input  wire logic mclk,
  input  wire logic serialOutPin,
  output var logic  serialInPin
);
  int bitT = 8;
  initial serialInPin = 1'b1;
  // A low final stop bit is cut short so the receiver does not take its tail for a new start.
  task automatic sendFrame(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      serialInPin <= f[i];
      repeat ((i == n - 1 && !f[i]) ? bitT * 3 / 4 : bitT) @(posedge mclk);
    end
    serialInPin <= 1'b1;
  endtask : sendFrame
  task automatic recvFrame(input int n, output logic [11:0] f);
    int k;
    f = 12'hfff;
    k = 0;
    while (serialOutPin !== 1'b0 && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    // A frame that never starts comes back all zero, which no expected frame matches.
    if (k >= 4000) begin
      f = 12'h000;
      return;
    end
    repeat (bitT / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      f[i] = serialOutPin;
      repeat (bitT) @(posedge mclk);
    end
  endtask : recvFrame
endmodule : serial_line_partner
`default_nettype wire

// *** bench/async_serial_interface_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_defs.svh"
module async_serial_interface_bench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        baudClockIn = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        serialInPin;
  logic        serialOutPin;
  logic        rxCompleteIrq;
  logic        txBufferFreeIrq;
  logic [7:0]  lfsr = 8'h35;
  logic [7:0]  ctl;
  int          miscompares = 0;
  int          checkCount = 0;
  async_serial_unit async_serial_unit_i (
    .mclk, .rst, .clkEn(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .serialInPin, .baudClockIn, .serialOutPin,
    .rxCompleteIrq, .txBufferFreeIrq
  );
  serial_line_partner partner_i (.mclk, .serialOutPin, .serialInPin);
  always #5 mclk = ~mclk;
  always @(posedge mclk) baudClockIn <= ~baudClockIn;
  task automatic stopTest;
    $display("Comparisons %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stopTest
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  function automatic logic expPar(input logic [1:0] m, input logic [7:0] d);
    return (m == 2'b10) ? ~^d : (m == 2'b11) ? ^d : 1'b0;
  endfunction : expPar
  // Builds the frame in time order; the receiver checks one stop bit only.
  function automatic int frame(input logic [7:0] d, input logic [7:0] c, input bit tx, output logic [11:0] f);
    int n;
    int nb;
    nb = c[1] ? 8 : 7;
    d = d & (c[1] ? 8'hff : 8'h7f);
    f = 12'hfff;
    f[0] = 1'b0;
    for (n = 1; n <= nb; n++) begin
      f[n] = c[4] ? d[n-1] : d[nb-n];
    end
    if (c[3:2] != 2'b00) begin
      f[n] = expPar(c[3:2], d);
      n++;
    end
    return n + 1 + int'(tx && c[0]);
  endfunction : frame
  task automatic waitRdy;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      stopTest();
    end
  endtask : waitRdy
  task automatic busOp(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    waitRdy();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    waitRdy();
    rd = hrdata;
  endtask : busOp
  task automatic busW(input logic [7:0] a, input logic [7:0] wd);
    logic [31:0] rd;
    busOp(1'b1, a, wd, rd);
  endtask : busW
  task automatic expectReg(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    busOp(1'b0, a, 8'h00, rd);
    check(rd, {24'h0, exp}, "register read");
  endtask : expectReg
  task automatic rxFrame(input logic [7:0] d, input logic [11:0] flip, input bit want);
    logic [11:0] f;
    int n;
    int k;
    bit seen;
    n = frame(d, ctl, 1'b0, f);
    seen = 1'b0;
    fork
      partner_i.sendFrame(f ^ flip, n);
      for (k = 0; k < n * partner_i.bitT + 40 && !seen; k++) begin
        @(posedge mclk);
        seen = (rxCompleteIrq === 1'b1);
      end
    join
    check({31'h0, seen}, {31'h0, want}, "receive interrupt");
  endtask : rxFrame
  task automatic rxRead(input logic [7:0] d, input logic [7:0] fl);
    expectReg(`OFF_RECEIVE_BUFFER, d);
    expectReg(`OFF_RECEPTION_ERROR_FLAGS, fl);
    expectReg(`OFF_RECEPTION_ERROR_FLAGS, 8'h00);
  endtask : rxRead
  initial begin
    logic [7:0]  d;
    logic [7:0]  dv;
    logic [3:0]  sel;
    logic [11:0] f;
    logic [11:0] g;
    int          n;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    expectReg(`OFF_SERIAL_CONTROL_0, 8'h10);
    expectReg(`OFF_SERIAL_CLOCK_SELECT, 8'h00);
    expectReg(`OFF_SERIAL_BAUD_DIVISOR, 8'h20);
    expectReg(`OFF_SERIAL_OPTION_CONTROL, 8'h00);
    busW(8'h1c, 8'hff);
    busW(`OFF_RECEIVE_BUFFER, 8'h5a);
    expectReg(8'h1c, 8'h00);
    expectReg(`OFF_RECEIVE_BUFFER, 8'h00);
    for (int i = 0; i < 4; i++) begin
      sel = (i == 1) ? 4'h1 : (i == 2) ? 4'hc : 4'h0;
      dv = (i == 3) ? 8'h02 : 8'h08;
      ctl = {3'b100, i[1], i[1:0], i[0], ~i[0]};
      partner_i.bitT = ((dv < 8'h04) ? 4 : int'(dv)) * ((sel >= 4'hc) ? 2 : (1 << sel));
      busW(`OFF_SERIAL_CLOCK_SELECT, {4'h0, sel});
      busW(`OFF_SERIAL_BAUD_DIVISOR, dv);
      busW(`OFF_SERIAL_CONTROL_0, ctl);
      ctl = ctl | 8'h60;
      busW(`OFF_SERIAL_CONTROL_0, ctl);
      busW(`OFF_SERIAL_CONTROL_0, ctl ^ 8'h10);
      expectReg(`OFF_SERIAL_CONTROL_0, ctl);
      d = rnd();
      n = frame(d, ctl, 1'b1, f);
      fork
        partner_i.recvFrame(n, g);
        busW(`OFF_TRANSMIT_BUFFER, d);
      join
      check({20'h0, g}, {20'h0, f}, "transmitted frame");
      d = rnd();
      rxFrame(d, 12'h000, 1'b1);
      rxRead(d & (ctl[1] ? 8'hff : 8'h7f), 8'h00);
    end
    busW(`OFF_SERIAL_BAUD_DIVISOR, 8'h08);
    busW(`OFF_SERIAL_CLOCK_SELECT, 8'h01);
    partner_i.bitT = 16;
    d = rnd();
    rxFrame(d, 12'h200, 1'b1);
    rxRead(d, 8'h04);
    d = rnd();
    rxFrame(d, 12'h400, 1'b1);
    rxRead(d, 8'h02);
    rxFrame(rnd(), 12'h000, 1'b1);
    d = rnd();
    rxFrame(d, 12'h000, 1'b1);
    rxRead(d, 8'h01);
    ctl = ctl & 8'hdf;
    busW(`OFF_SERIAL_CONTROL_0, ctl);
    rxFrame(rnd(), 12'h000, 1'b0);
    expectReg(`OFF_RECEIVE_BUFFER, d);
    busW(`OFF_SERIAL_CONTROL_0, 8'h00);
    busW(`OFF_TRANSMIT_BUFFER, rnd());
    repeat (40) @(posedge mclk);
    check({31'h0, serialOutPin}, 32'h1, "idle line");
    stopTest();
  end
endmodule : async_serial_interface_bench
`default_nettype wire
